/* File: src/dac_pin_ctrl.sv */
// Pin-level control of a multi-channel converter with serial/parallel port
`timescale 1ns/1ps
`default_nettype none
module dac_pin_ctrl
   import dac_pin_pkg::*;
#(
   parameter int WORD_LEN = WORD_W,
   parameter int ACQ_LEN  = ACQ_CYC
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              arst_n,
   // Host pins, asynchronous to clock
   input  wire logic              frame_n,
   input  wire logic              write_n,
   input  wire logic              offset_pick,
   input  wire logic              sclk,
   input  wire logic              sdin,
   input  wire logic              interface_choice,
   input  wire logic              acquire,
   input  wire logic [CHAN_W-1:0] par_addr,
   // Pins to the host and analog core
   output logic                   sdout,
   output logic                   busy_n,
   output logic                   track_through,
   output logic [CHAN_W-1:0]      acq_chan,
   output logic                   acq_offset,
   output logic                   infinite_hold_mode,
   // Register port
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling

   pins_t               pin_raw;
   pins_t               pin_meta;
   pins_t               pin_now;
   pins_t               pin_old;

   assign pin_raw = '{frame_n, write_n, offset_pick, sclk, sdin,
                      interface_choice, acquire, par_addr};

   // Two flops before use, third only for edge detection
   // Reset to idle pin levels, so no false edge follows reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, '0};
         pin_now  <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, '0};
         pin_old  <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, '0};
      end else begin
         pin_meta <= pin_raw;
         pin_now  <= pin_meta;
         pin_old  <= pin_now;
      end
   end

   function automatic logic fell(input logic was, input logic is);
      return was & ~is;
   endfunction

   logic                sclk_fall;
   logic                sclk_rise;
   logic                frame_fall;
   logic                acq_rise;
   logic                acq_fall;

   assign sclk_fall  = fell(pin_old.sclk, pin_now.sclk);
   assign sclk_rise  = fell(pin_now.sclk, pin_old.sclk);
   assign frame_fall = fell(pin_old.frame_n, pin_now.frame_n);
   assign acq_rise   = fell(pin_now.acquire, pin_old.acquire);
   assign acq_fall   = fell(pin_old.acquire, pin_now.acquire);

   ////////////////////////////////////////////////////////////////////////
   // Registers seen by software

   logic [EV_W-1:0]     status;
   logic [EV_W-1:0]     mask;
   logic [CTRL_W-1:0]   ctrl;
   logic [EV_W-1:0]     events;
   logic [WORD_LEN-1:0] last_word;
   logic                port_en;

   assign port_en = ctrl[CTRL_ENABLE];

   ////////////////////////////////////////////////////////////////////////
   // Reset pulse detection on acquire control

   logic [LOW_W-1:0]    low_cnt;
   logic                soft_rst;
   logic                acq_go;

   // Saturating count of the low time
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt <= '0;
      end else if (acq_fall) begin
         low_cnt <= LOW_W'(1);
      end else if (!pin_now.acquire && low_cnt <= LOW_W'(RST_MAX_CYC)) begin
         low_cnt <= low_cnt + LOW_W'(1);
      end
   end

   // Both edges see the same sync delay, so the width is kept
   assign soft_rst = acq_rise
                   && low_cnt >= LOW_W'(RST_MIN_CYC)
                   && low_cnt <= LOW_W'(RST_MAX_CYC);
   assign acq_go   = acq_rise && !soft_rst;

   ////////////////////////////////////////////////////////////////////////
   // Channel registers and addressing

   logic [DATA_W-1:0]   chan_mem [NUM_CHAN];
   target_t             target;
   target_t             next_target;
   logic                addr_hit;
   logic                par_hit;
   logic                ser_hit;
   logic [WORD_LEN-1:0] next_word;
   logic                word_done;

   // Parallel access: select and write both low, newly
   assign par_hit = port_en && !pin_now.interface_choice
                  && !pin_now.frame_n && !pin_now.write_n
                  && (pin_old.frame_n || pin_old.write_n);
   assign addr_hit = par_hit || ser_hit;

   always_comb begin
      next_target = target;
      if (par_hit) begin
         next_target.offset = pin_now.offset_pick;
         next_target.chan   = pin_now.addr;
      end else if (ser_hit) begin
         next_target.offset = 1'b0;
         next_target.chan   = next_word[ADDR_HI:ADDR_LO];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         target <= '0;
      end else if (soft_rst) begin
         target <= '0;
      end else begin
         target <= next_target;
      end
   end

   // Stored codes, cleared only by the pin reset, not by arst_n
   always_ff @(posedge clock) begin
      if (soft_rst) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            chan_mem[i] <= '0;
         end
      end else if (ser_hit && !next_word[RB_BIT]) begin
         chan_mem[next_word[ADDR_HI:ADDR_LO]] <= next_word[DATA_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial port

   ser_t                ser_state;
   logic [WORD_LEN-1:0] shift_in;
   logic [DATA_W-1:0]   shift_out;
   logic [ACQ_W-1:0]    bit_cnt;

   assign next_word = {shift_in[WORD_LEN-2:0], pin_now.sdin};
   assign word_done = ser_state == SER_SHIFT && sclk_fall
                    && bit_cnt == ACQ_W'(WORD_LEN - 1);
   assign ser_hit   = word_done;

   // Frame low opens shifting; frame high ends any phase
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ser_state <= SER_IDLE;
         shift_in  <= '0;
         shift_out <= '0;
         bit_cnt   <= '0;
         sdout     <= 1'b0;
         last_word <= '0;
      end else if (soft_rst || pin_now.frame_n) begin
         ser_state <= SER_IDLE;
         sdout     <= 1'b0;
      end else begin
         unique case (ser_state)
            SER_IDLE: begin
               if (frame_fall && port_en && pin_now.interface_choice) begin
                  ser_state <= SER_SHIFT;
                  bit_cnt   <= '0;
               end
            end
            SER_SHIFT: begin
               if (sclk_fall) begin
                  shift_in <= next_word;
                  bit_cnt  <= bit_cnt + ACQ_W'(1);
               end
               if (word_done) begin
                  last_word <= next_word;
                  if (next_word[RB_BIT]) begin
                     shift_out <= chan_mem[next_word[ADDR_HI:ADDR_LO]];
                     ser_state <= SER_READ;
                  end else begin
                     ser_state <= SER_WAIT;
                  end
               end
            end
            SER_READ: begin
               if (sclk_rise) begin
                  sdout     <= shift_out[DATA_W-1];
                  shift_out <= {shift_out[DATA_W-2:0], 1'b0};
               end
            end
            SER_WAIT: begin
               ser_state <= SER_WAIT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acquisition timing and busy

   logic [ACQ_W-1:0]    acq_cnt;
   logic                acq_start;
   logic                acq_end;

   assign acq_start = (addr_hit && pin_now.acquire) || acq_go;
   assign acq_end   = !busy_n && acq_cnt == '0;

   // A new address with acquire high restarts the acquisition time on the new channel
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busy_n  <= 1'b1;
         acq_cnt <= '0;
      end else if (soft_rst) begin
         busy_n  <= 1'b1;
         acq_cnt <= '0;
      end else if (acq_start) begin
         busy_n  <= 1'b0;
         acq_cnt <= ACQ_W'(ACQ_LEN - 1);
      end else if (acq_end) begin
         busy_n  <= 1'b1;
      end else if (!busy_n) begin
         acq_cnt <= acq_cnt - ACQ_W'(1);
      end
   end

   // Outputs toward the analog core
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         track_through      <= 1'b0;
         acq_chan           <= '0;
         acq_offset         <= 1'b0;
         infinite_hold_mode <= 1'b0;
      end else begin
         track_through      <= !pin_now.acquire;
         acq_chan           <= target.chan;
         acq_offset         <= target.offset;
         infinite_hold_mode <= ctrl[CTRL_HOLD];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port and interrupt

   assign events = {soft_rst, acq_end, acq_start, word_done};

   // Write one to clear; a new event wins over the clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         status <= '0;
         mask   <= '0;
         ctrl   <= CTRL_RESET;
      end else begin
         if (reg_wr && reg_addr == OFS_STATUS) begin
            status <= (status & ~reg_wdata[EV_W-1:0]) | events;
         end else begin
            status <= status | events;
         end
         if (reg_wr && reg_addr == OFS_MASK) begin
            mask <= reg_wdata[EV_W-1:0];
         end
         if (reg_wr && reg_addr == OFS_CTRL) begin
            ctrl <= reg_wdata[CTRL_W-1:0];
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
         irq       <= 1'b0;
      end else begin
         irq       <= |(status & mask);
         reg_rdata <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               OFS_STATUS: reg_rdata <= 32'(status);
               OFS_MASK:   reg_rdata <= 32'(mask);
               OFS_CTRL:   reg_rdata <= 32'(ctrl);
               OFS_STATE:  reg_rdata <= 32'({pin_now.interface_choice,
                                             !pin_now.acquire, target,
                                             ser_state, busy_n});
               OFS_WORD:   reg_rdata <= 32'(last_word);
               default:    reg_rdata <= '0;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* File: src/dac_pin_pkg.sv */
// Constants, types and timing for the converter pin-interface control
`default_nettype none
package dac_pin_pkg;
   // Serial word layout, MSB first
   localparam int CHAN_W     = 5;
   localparam int DATA_W     = 14;
   localparam int WORD_W     = 20;
   localparam int RB_BIT     = 19;
   localparam int ADDR_HI    = 18;
   localparam int ADDR_LO    = 14;
   localparam int NUM_CHAN   = 32;

   // Timing at the system clock rate
   localparam int CLK_NS     = 20;
   localparam int RST_MIN_NS = 90;
   localparam int RST_MAX_NS = 200;
   localparam int ACQ_NS     = 16000;
   localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_MAX_CYC = RST_MAX_NS / CLK_NS;
   localparam int ACQ_CYC     = ACQ_NS / CLK_NS;
   localparam int LOW_W       = 5;
   localparam int ACQ_W       = 12;

   // Register map, byte addresses
   localparam int REG_AW = 8;
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_STATE  = 8'h0c;
   localparam logic [7:0] OFS_WORD   = 8'h10;

   // Event bits of status and mask
   localparam int EV_W         = 4;
   localparam int EV_FRAME     = 0;
   localparam int EV_ACQ_START = 1;
   localparam int EV_ACQ_DONE  = 2;
   localparam int EV_RESET     = 3;

   // Control bits
   localparam int CTRL_W       = 2;
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_HOLD    = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;

   // Pins from the host, sampled as one group
   typedef struct packed {
      logic              frame_n;
      logic              write_n;
      logic              offset_pick;
      logic              sclk;
      logic              sdin;
      logic              interface_choice;
      logic              acquire;
      logic [CHAN_W-1:0] addr;
   } pins_t;

   // Channel being addressed
   typedef struct packed {
      logic              offset;
      logic [CHAN_W-1:0] chan;
   } target_t;

   typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_READ, SER_WAIT} ser_t;
endpackage
`default_nettype wire

/* File: bench/dac_pin_assertions.sv */
// Checker for the converter pin-interface control
`timescale 1ns/1ps
`default_nettype none
module dac_pin_checker
   import dac_pin_pkg::*;
#(parameter int ACQ_LEN = ACQ_CYC)
(
   // Clock, reset and host pins
   input wire logic              clock,
   input wire logic              arst_n,
   input wire logic              frame_n,
   input wire logic              write_n,
   input wire logic              offset_pick,
   input wire logic              sclk,
   input wire logic              interface_choice,
   input wire logic              acquire,
   // Outputs and register port
   input wire logic              sdout,
   input wire logic              busy_n,
   input wire logic              track_through,
   input wire logic [CHAN_W-1:0] acq_chan,
   input wire logic              acq_offset,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata
);
   // Two cycles of slack for the synchronised start
   localparam int ACQ_TOP = ACQ_LEN + 2;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////
   // Low widths: too long for a reset, inside the reset window
   sequence s_long_low; !acquire [*8] ##1 !acquire [*4]; endsequence
   sequence s_short_low; acquire ##1 !acquire [*6] ##1 acquire; endsequence
   sequence s_par_ofs;
      (!interface_choice && offset_pick && !frame_n && !write_n) [*4];
   endsequence
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_track_on; !acquire [*4] |=> track_through; endproperty
   property p_track_off; acquire [*4] |=> !track_through; endproperty
   property p_busy_min; $fell(busy_n) |-> !busy_n [*8]; endproperty
   property p_busy_end; $fell(busy_n) |-> ##[1:ACQ_TOP] busy_n; endproperty
   property p_rise_acq; s_long_low ##1 acquire |-> ##[1:6] !busy_n;
   endproperty
   property p_pin_reset;
      s_short_low |-> ##8 (busy_n && acq_chan == 5'h00 && !acq_offset);
   endproperty
   property p_ser_ofs; interface_choice [*6] |-> !$rose(acq_offset);
   endproperty
   property p_par_ofs; s_par_ofs |-> ##[1:6] acq_offset; endproperty
   // Readback bit may only move in the high half of the shift clock
   property p_rb_stable; !sclk [*4] |-> $stable(sdout); endproperty
   property p_idle; frame_n [*6] |=> !sdout; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
   a_track_on: assert property (p_track_on)
      else $error("no tracking while acquire low");
   a_track_off: assert property (p_track_off)
      else $error("tracking while acquire high");
   a_busy_min: assert property (p_busy_min)
      else $error("busy too short");
   a_busy_end: assert property (p_busy_end)
      else $error("busy never ends");
   a_rise_acq: assert property (p_rise_acq)
      else $error("rise did not start acquisition");
   a_pin_reset: assert property (p_pin_reset)
      else $error("short pulse did not reset");
   a_ser_ofs: assert property (p_ser_ofs)
      else $error("offset picked in serial mode");
   a_par_ofs: assert property (p_par_ofs)
      else $error("offset channel not picked");
   a_rb_stable: assert property (p_rb_stable)
      else $error("readback moved in low phase");
   a_idle: assert property (p_idle)
      else $error("readback active outside frame");
endmodule
bind dac_pin_ctrl dac_pin_checker #(.ACQ_LEN(ACQ_LEN)) chk (
   .clock(clock), .arst_n(arst_n), .frame_n(frame_n), .write_n(write_n),
   .offset_pick(offset_pick), .sclk(sclk),
   .interface_choice(interface_choice), .acquire(acquire), .sdout(sdout),
   .busy_n(busy_n), .track_through(track_through), .acq_chan(acq_chan),
   .acq_offset(acq_offset), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

/* File: bench/host_model.sv */
// Host model: drives the serial port and the shared select line
`timescale 1ns/1ps
`default_nettype none
module host_model
   import dac_pin_pkg::*;
(
   // System clock, pins move on its rising edge
   input  wire logic clock,
   // Serial port pins
   output logic      frame_n,
   output logic      sclk,
   output logic      sdin,
   input  wire logic sdout
);
   // Idle: clock parked high, data at its pull-up level
   initial begin
      frame_n = 1'b1;
      sclk    = 1'b1;
      sdin    = 1'b1;
   end
   // Shared line used as parallel chip select
   task automatic select(input logic v);
      frame_n <= v;
   endtask
   // One frame, MSB first; 160 ns period stays under the clock limit
   task automatic xfer(input logic [WORD_W-1:0] w, input int rd_n,
                       output logic [DATA_W-1:0] rb);
      rb = '0;
      @(posedge clock);
      frame_n <= 1'b0;
      for (int i = 0; i < WORD_W + rd_n; i++) begin
         sdin <= (i < WORD_W) ? w[WORD_W-1-i] : ~sdin;
         repeat (4) @(posedge clock);
         if (i >= WORD_W) rb = {rb[DATA_W-2:0], sdout};
         sclk <= 1'b0;
         repeat (4) @(posedge clock);
         sclk <= 1'b1;
      end
      repeat (2) @(posedge clock);
      frame_n <= 1'b1;
      sdin    <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the converter pin-interface control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dac_pin_pkg::*;
   // Short acquisition keeps the run brief
   localparam int ACQ = 20;
   logic              clock, arst_n, write_n, offset_pick, sclk, sdin;
   logic              frame_n, interface_choice, acquire, sdout, busy_n;
   logic              track_through, acq_offset, infinite_hold_mode, irq;
   logic              reg_wr, reg_rd;
   logic [CHAN_W-1:0] par_addr, acq_chan;
   logic [REG_AW-1:0] reg_addr;
   logic [31:0]       reg_wdata, reg_rdata;
   logic [DATA_W-1:0] rb;
   int                num_errors = 0;
   int                n_tests = 0;
   dac_pin_ctrl #(.ACQ_LEN(ACQ)) dut (.clock, .arst_n, .frame_n, .write_n,
      .offset_pick, .sclk, .sdin, .interface_choice, .acquire, .par_addr,
      .sdout, .busy_n, .track_through, .acq_chan, .acq_offset,
      .infinite_hold_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq);
   host_model host (.clock, .frame_n, .sclk, .sdin, .sdout);
   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   ////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Register port: one-cycle strobes launched after the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   // Bounded wait on busy; a hang ends the run
   task automatic wait_busy(input logic v);
      for (int i = 0; i < 200 && busy_n !== v; i++) begin
         @(posedge clock);
         #1;
      end
      check(busy_n, v);
      if (busy_n !== v) print_verdict();
   endtask
   // Parallel access held for four clocks
   task automatic par(input logic [CHAN_W-1:0] a, input logic ofs);
      @(posedge clock);
      par_addr    <= a;
      offset_pick <= ofs;
      write_n     <= 1'b0;
      host.select(1'b0);
      repeat (4) @(posedge clock);
      write_n <= 1'b1;
      host.select(1'b1);
   endtask
   ////////////////////
   initial begin
      arst_n           = 1'b0;
      write_n          = 1'b1;
      offset_pick      = 1'b0;
      interface_choice = 1'b0;
      acquire          = 1'b1;
      par_addr         = 5'h00;
      reg_addr         = 8'h00;
      reg_wdata        = 32'h0;
      reg_wr           = 1'b0;
      reg_rd           = 1'b0;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      rdchk(OFS_CTRL, 32'h1);
      rdchk(OFS_STATUS, 32'h0);
      wr(8'h20, 32'hffffffff);
      rdchk(8'h20, 32'h0);
      // Offset channel, then a regular one, in parallel mode
      par(5'h0a, 1'b1);
      wait_busy(1'b0);
      wait_busy(1'b1);
      check(acq_offset, 1'b1);
      par(5'h11, 1'b0);
      wait_busy(1'b0);
      wait_busy(1'b1);
      check(acq_chan, 5'h11);
      check(acq_offset, 1'b0);
      rdchk(OFS_STATUS, 32'h6);
      wr(OFS_STATUS, 32'hf);
      rdchk(OFS_STATUS, 32'h0);
      // Serial mode: parallel access ignored, then write and readback
      @(posedge clock) interface_choice <= 1'b1;
      par(5'h05, 1'b1);
      repeat (10) @(posedge clock);
      check(busy_n, 1'b1);
      check(acq_chan, 5'h11);
      host.xfer({1'b0, 5'h03, 14'h1abc}, 0, rb);
      wait_busy(1'b1);
      check(acq_chan, 5'h03);
      rdchk(OFS_WORD, 32'h0dabc);
      rdchk(OFS_STATUS, 32'h7);
      host.xfer({1'b1, 5'h03, 14'h0}, 14, rb);
      check(rb, 14'h1abc);
      wait_busy(1'b1);
      // Masked and unmasked events on the interrupt line
      wr(OFS_STATUS, 32'hf);
      wr(OFS_MASK, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      host.xfer({1'b0, 5'h04, 14'h0155}, 0, rb);
      repeat (4) @(posedge clock);
      check(irq, 1'b1);
      wr(OFS_STATUS, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      wait_busy(1'b1);
      wr(OFS_CTRL, 32'h3);
      repeat (2) @(posedge clock);
      check(infinite_hold_mode, 1'b1);
      wr(OFS_CTRL, 32'h1);
      // Long low is tracking only; its rise acquires
      @(posedge clock) acquire <= 1'b0;
      repeat (20) @(posedge clock);
      check(track_through, 1'b1);
      check(busy_n, 1'b1);
      acquire <= 1'b1;
      wait_busy(1'b0);
      wait_busy(1'b1);
      check(acq_chan, 5'h04);
      // Short low pulse resets the device, not the registers
      wr(OFS_STATUS, 32'hf);
      @(posedge clock) acquire <= 1'b0;
      repeat (6) @(posedge clock);
      acquire <= 1'b1;
      repeat (12) @(posedge clock);
      check(acq_chan, 5'h00);
      check(busy_n, 1'b1);
      rdchk(OFS_STATUS, 32'h8);
      rdchk(OFS_CTRL, 32'h1);
      // Port disabled: a full serial word is ignored
      wr(OFS_CTRL, 32'h0);
      host.xfer({1'b0, 5'h07, 14'h0123}, 0, rb);
      repeat (4) @(posedge clock);
      check(busy_n, 1'b1);
      check(acq_chan, 5'h00);
      rdchk(OFS_WORD, 32'h10155);
      rdchk(OFS_STATE, 32'h401);
      rdchk(OFS_STATUS, 32'h8);
      print_verdict();
   end
endmodule
`default_nettype wire
